// ===== ram_angle_consts.vh
// Purpose: Constants for the ram angle and reversal logic
// Assumes: Position and pressure samples are unsigned 16-bit counts
// Notes: Counts derive from the 250 MHz system clock
`ifndef RAM_ANGLE_CONSTS_VH
`define RAM_ANGLE_CONSTS_VH
`define POS_W 16
`define ANG_W 9
`define ANG_TOP 9'h000
`define ANG_BOTTOM 9'h0b4
`define ANG_FULL 9'h168
`define LIMIT_RST 16'h0000
`define DWELL_W 24
`define DWELL_TICK_NS 1000
`define CLK_PERIOD_NS 4
`define DWELL_TICK_CYC ((`DWELL_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_W 8
`endif

// ===== ram_angle_reversal.v
// Purpose: Ram stroke angle, incomplete-stroke fault and ram reversal control
// Assumes: Larger position count means ram lower; upper limit below lower limit in count
// Notes: Dwell time is given in microseconds; all pin inputs but clock and reset are synchronised
// Summary of operation
// - Upper limit is 0, lower is 180
// - Span split in 180 steps, upstroke to 360
// - Hold 180 beyond lower limit on downstroke
// - Upstroke angle rises after passing lower limit
// - Hold 0 above upper until next downstroke
// - Fault on uncommanded reversal before opposite limit
// - Fault inhibits stroke until operator reset
// - Distance mode returns ram at lower limit
// - Force mode returns at tonnage or limit
// - Dwell at tonnage before commanding return
// - Reversal on channel 4 in force mode only; dwell on 3
// - Clear limits, or latch position into limit
// - After tool change rise, never descend early
// - Current stroke tonnage offered for display
`timescale 1ns/10ps
`include "ram_angle_consts.vh"
module ram_angle_reversal (
  input wire SYS_CLK_I,
  input wire SYS_RST_I,
  input wire [15:0] POSITION_I,
  input wire [15:0] PRESSURE_I,
  input wire [15:0] MAX_TONNAGE_I,
  input wire [23:0] DWELL_TIME_I,
  input wire REVERSE_ON_FORCE_OR_BOTTOM_MODE_I,
  input wire CLEAR_LIMITS_I,
  input wire SET_UPPER_I,
  input wire SET_LOWER_I,
  input wire OPERATOR_RESET_I,
  input wire TOOL_CHANGE_I,
  output reg [8:0] ANGLE_O,
  output reg [15:0] UPPER_LIMIT_O,
  output reg [15:0] LOWER_LIMIT_O,
  output reg FAULT_O,
  output reg STROKE_INHIBIT_O,
  output reg CHANNEL3_O,
  output reg CHANNEL4_O,
  output reg RETURN_O,
  output reg [15:0] TONNAGE_O
);
  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  localparam SW = 16 + 16 + 16 + 24 + 6;
  wire [SW-1:0] raw_w;
  reg [SW-1:0] meta_q;
  reg [SW-1:0] sync_q;
  assign raw_w = {POSITION_I, PRESSURE_I, MAX_TONNAGE_I, DWELL_TIME_I,
    REVERSE_ON_FORCE_OR_BOTTOM_MODE_I, CLEAR_LIMITS_I, SET_UPPER_I, SET_LOWER_I,
    OPERATOR_RESET_I, TOOL_CHANGE_I};
  always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      meta_q <= {SW{1'b0}};
      sync_q <= {SW{1'b0}};
    end else begin
      meta_q <= raw_w;
      sync_q <= meta_q;
    end
  end
  wire [15:0] pos_w = sync_q[SW-1 -: 16];
  wire [15:0] press_w = sync_q[SW-17 -: 16];
  wire [15:0] max_ton_w = sync_q[SW-33 -: 16];
  wire [23:0] dwell_w = sync_q[SW-49 -: 24];
  wire force_mode_w = sync_q[5];
  wire clear_w = sync_q[4];
  wire set_up_w = sync_q[3];
  wire set_lo_w = sync_q[2];
  wire op_rst_w = sync_q[1];
  wire tool_chg_w = sync_q[0];

  // -----------------------------------------------------------------
  // Stroke limits and interpolation
  // -----------------------------------------------------------------
  wire [15:0] span_w = LOWER_LIMIT_O - UPPER_LIMIT_O;
  wire [15:0] depth_w = pos_w - UPPER_LIMIT_O;
  wire above_up_w = (pos_w <= UPPER_LIMIT_O);
  wire below_lo_w = (pos_w >= LOWER_LIMIT_O);
  wire limits_ok_w = (LOWER_LIMIT_O > UPPER_LIMIT_O);
  wire [23:0] scaled_w = {8'h00, depth_w} * 24'h0000b4;
  // Divider is combinational; fine for a sample rate far below the clock
  wire [23:0] quot_w = (span_w == 16'h0000) ? 24'h000000 : scaled_w / {8'h00, span_w};
  wire [8:0] frac_w = (quot_w > 24'h0000b4) ? `ANG_BOTTOM : quot_w[8:0];

  always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      UPPER_LIMIT_O <= `LIMIT_RST;
      LOWER_LIMIT_O <= `LIMIT_RST;
    end else if (clear_w) begin
      UPPER_LIMIT_O <= `LIMIT_RST;
      LOWER_LIMIT_O <= `LIMIT_RST;
    end else begin
      if (set_up_w)
        UPPER_LIMIT_O <= pos_w;
      if (set_lo_w)
        LOWER_LIMIT_O <= pos_w;
    end
  end

  // -----------------------------------------------------------------
  // Stroke state machine
  // -----------------------------------------------------------------
  localparam ST_TOP = 2'b00;
  localparam ST_DOWN = 2'b01;
  localparam ST_BOTTOM = 2'b10;
  localparam ST_UP = 2'b11;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [8:0] ang_d;
  reg fault_set_w;
  reg hold_high_q;
  reg hold_high_d;

  always @* begin
    st_d = st_q;
    ang_d = ANGLE_O;
    fault_set_w = 1'b0;
    hold_high_d = hold_high_q;
    if (!limits_ok_w) begin
      st_d = ST_TOP;
      ang_d = `ANG_TOP;
    end else begin
      case (st_q)
        ST_TOP: begin
          ang_d = `ANG_TOP;
          if (!above_up_w) begin
            st_d = ST_DOWN;
            ang_d = frac_w;
          end
        end
        ST_DOWN: begin
          ang_d = frac_w;
          if (below_lo_w) begin
            st_d = ST_BOTTOM;
            ang_d = `ANG_BOTTOM;
            hold_high_d = 1'b0;
          end else if (RETURN_O) begin
            // Commanded reversal short of the bottom counts as a full stroke
            st_d = ST_UP;
            ang_d = (frac_w == `ANG_TOP) ? `ANG_TOP : `ANG_FULL - frac_w;
          end else if (above_up_w) begin
            st_d = ST_TOP;
            ang_d = `ANG_TOP;
            fault_set_w = 1'b1;
          end
        end
        ST_BOTTOM: begin
          ang_d = `ANG_BOTTOM;
          if (!below_lo_w) begin
            st_d = ST_UP;
            ang_d = `ANG_FULL - frac_w;
          end
        end
        ST_UP: begin
          ang_d = (frac_w == `ANG_TOP) ? `ANG_TOP : `ANG_FULL - frac_w;
          if (above_up_w) begin
            st_d = ST_TOP;
            ang_d = `ANG_TOP;
          end else if (below_lo_w) begin
            st_d = ST_BOTTOM;
            ang_d = `ANG_BOTTOM;
            fault_set_w = 1'b1;
          end
        end
        default: begin
          st_d = ST_TOP;
        end
      endcase
    end
    // Raise after a tool change ends once the ram is at the top
    if (limits_ok_w && above_up_w)
      hold_high_d = 1'b0;
    if (tool_chg_w)
      hold_high_d = 1'b1;
  end

  always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_q <= ST_TOP;
      ANGLE_O <= `ANG_TOP;
      FAULT_O <= 1'b0;
      STROKE_INHIBIT_O <= 1'b0;
      hold_high_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ANGLE_O <= ang_d;
      hold_high_q <= hold_high_d;
      // New fault wins over a coincident operator reset
      if (fault_set_w) begin
        FAULT_O <= 1'b1;
        STROKE_INHIBIT_O <= 1'b1;
      end else if (op_rst_w) begin
        FAULT_O <= 1'b0;
        STROKE_INHIBIT_O <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Reversal, dwell and tonnage
  // -----------------------------------------------------------------
  reg [7:0] tick_q;
  reg [23:0] dwell_q;
  reg dwell_act_q;
  wire [31:0] tick_last_w = `DWELL_TICK_CYC - 1;
  wire tick_w = (tick_q == tick_last_w[7:0]);
  wire at_force_w = force_mode_w && (press_w >= max_ton_w);
  wire in_stroke_w = (st_q == ST_DOWN);

  always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tick_q <= 8'h00;
      dwell_q <= 24'h000000;
      dwell_act_q <= 1'b0;
      RETURN_O <= 1'b0;
      CHANNEL3_O <= 1'b0;
      CHANNEL4_O <= 1'b0;
      TONNAGE_O <= 16'h0000;
    end else begin
      tick_q <= tick_w ? 8'h00 : tick_q + 8'h01;
      TONNAGE_O <= (st_q == ST_TOP) ? 16'h0000 : (press_w > TONNAGE_O ? press_w : TONNAGE_O);
      if (st_q != ST_DOWN || FAULT_O) begin
        dwell_act_q <= 1'b0;
        CHANNEL3_O <= 1'b0;
      end
      if (FAULT_O || !limits_ok_w) begin
        RETURN_O <= 1'b0;
        CHANNEL4_O <= 1'b0;
      end else if (hold_high_q && above_up_w) begin
        RETURN_O <= 1'b0;
        CHANNEL4_O <= 1'b0;
      end else if (hold_high_q && !above_up_w) begin
        RETURN_O <= 1'b1;
      end else if (in_stroke_w && below_lo_w) begin
        RETURN_O <= 1'b1;
        CHANNEL4_O <= force_mode_w;
      end else if (in_stroke_w && at_force_w && !dwell_act_q) begin
        dwell_act_q <= 1'b1;
        dwell_q <= dwell_w;
        // Restart the microsecond tick so the dwell is never cut short
        tick_q <= 8'h00;
        CHANNEL3_O <= 1'b1;
      end else if (dwell_act_q) begin
        if (dwell_q == 24'h000000) begin
          RETURN_O <= 1'b1;
          CHANNEL4_O <= 1'b1;
        end else if (tick_w) begin
          dwell_q <= dwell_q - 24'h000001;
        end
      end else if (st_q == ST_TOP) begin
        RETURN_O <= 1'b0;
        CHANNEL4_O <= 1'b0;
      end
    end
  end
endmodule // ram_angle_reversal

// ===== ram_angle_checks_properties.sv
// Purpose: Port checks for the ram angle block
// Assumes: Inputs reach the logic 3 edges after a pin change
// Notes: Bound to every instance
`timescale 1ns/10ps
module ram_angle_checks (
  input wire SYS_CLK_I, SYS_RST_I, REVERSE_ON_FORCE_OR_BOTTOM_MODE_I,
  input wire CLEAR_LIMITS_I, SET_UPPER_I, SET_LOWER_I, OPERATOR_RESET_I,
  input wire [15:0] POSITION_I, UPPER_LIMIT_O, LOWER_LIMIT_O,
  input wire [8:0] ANGLE_O,
  input wire FAULT_O, STROKE_INHIBIT_O, CHANNEL3_O, CHANNEL4_O, RETURN_O
);
  // ----
  // Checks
  // ----
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_angle_range: assert property (ANGLE_O < 9'h168) else $error("angle range");
  a_inhibit_follows: assert property (FAULT_O |-> ##[0:1] STROKE_INHIBIT_O)
    else $error("no inhibit");
  a_fault_release: assert property ($fell(FAULT_O) |-> $past(OPERATOR_RESET_I, 2)
    || $past(OPERATOR_RESET_I, 3) || $past(OPERATOR_RESET_I, 4)) else $error("fault fell");
  a_clear_limits: assert property (CLEAR_LIMITS_I [*4] |=> UPPER_LIMIT_O == 16'h0000
    && LOWER_LIMIT_O == 16'h0000) else $error("clear");
  a_set_upper: assert property ((SET_UPPER_I && !CLEAR_LIMITS_I && $stable(POSITION_I)) [*4]
    |=> UPPER_LIMIT_O == $past(POSITION_I)) else $error("upper");
  a_set_lower: assert property ((SET_LOWER_I && !CLEAR_LIMITS_I && $stable(POSITION_I)) [*4]
    |=> LOWER_LIMIT_O == $past(POSITION_I)) else $error("lower");
  a_ch4_force: assert property ($rose(CHANNEL4_O)
    |-> $past(REVERSE_ON_FORCE_OR_BOTTOM_MODE_I, 3)) else $error("ch4 mode");
  a_dwell_first: assert property ($rose(CHANNEL3_O) |-> !RETURN_O && !CHANNEL4_O)
    else $error("dwell");
  a_fault_no_return: assert property (FAULT_O |=> !RETURN_O)
    else $error("return during fault");
endmodule // ram_angle_checks
bind ram_angle_reversal ram_angle_checks i_chk (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
  .REVERSE_ON_FORCE_OR_BOTTOM_MODE_I(REVERSE_ON_FORCE_OR_BOTTOM_MODE_I),
  .CLEAR_LIMITS_I(CLEAR_LIMITS_I), .SET_UPPER_I(SET_UPPER_I), .SET_LOWER_I(SET_LOWER_I),
  .OPERATOR_RESET_I(OPERATOR_RESET_I), .POSITION_I(POSITION_I),
  .UPPER_LIMIT_O(UPPER_LIMIT_O), .LOWER_LIMIT_O(LOWER_LIMIT_O), .ANGLE_O(ANGLE_O),
  .FAULT_O(FAULT_O), .STROKE_INHIBIT_O(STROKE_INHIBIT_O), .CHANNEL3_O(CHANNEL3_O),
  .CHANNEL4_O(CHANNEL4_O), .RETURN_O(RETURN_O));

// ===== ram_press_model.sv
// Purpose: Ram, sensor and main control seen by the block
// Assumes: One count of travel every 16 cycles
// Notes: Dwell request freezes descent
`timescale 1ns/10ps
module ram_press_model #(parameter logic [15:0] TOP = 16'h00f0, CONTACT = 16'h0190) (
  input wire logic clk_i,
  input wire logic return_i,
  input wire logic dwell_i,
  input wire logic [15:0] target_i,
  output logic [15:0] position_o = TOP,
  output logic [15:0] pressure_o
);
  logic [3:0] tick = 4'h0;
  wire [15:0] goal = return_i ? TOP : target_i;
  always @(posedge clk_i) begin
    tick <= tick + 4'h1;
    if (tick == 4'h0 && !dwell_i && goal > position_o) position_o <= position_o + 16'h0001;
    else if (tick == 4'h0 && goal < position_o) position_o <= position_o - 16'h0001;
  end
  // Force builds only once the tool touches
  assign pressure_o = (position_o > CONTACT) ? position_o - CONTACT : 16'h0000;
endmodule // ram_press_model

// ===== ram_angle_reversal_bench.sv
// Purpose: Bench for ram angle and reversal
// Assumes: Span of 180 counts, so one degree per count
// Notes: Checks wait 6 cycles after each ram step
`timescale 1ns/10ps
`define CHK(a,b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module ram_angle_reversal_bench;
  logic clk = 0, rst = 1, mode = 0, clr = 0, su = 0, sl = 0, orst = 0, tc = 0;
  logic [15:0] tgt = 16'h0100, pos, prs, upl, lwl, ton;
  logic [8:0] ang;
  logic flt, inh, c3, c4, ret;
  int miscompares = 0, checked = 0, n;
  logic [25:0] rows [6] = '{{16'h0110, 9'h010, 1'b0}, {16'h015a, 9'h05a, 1'b0},
    {16'h01b4, 9'h0b4, 1'b1}, {16'h01a0, 9'h0c8, 1'b1}, {16'h0101, 9'h167, 1'b1},
    {16'h00f0, 9'h000, 1'b0}};
  initial forever #2 clk = ~clk;
  ram_press_model i_ram (.clk_i(clk), .return_i(ret), .dwell_i(c3), .target_i(tgt),
    .position_o(pos), .pressure_o(prs));
  ram_angle_reversal i_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .POSITION_I(pos),
    .PRESSURE_I(prs), .MAX_TONNAGE_I(16'h0010), // Kept below capacity
    .DWELL_TIME_I(24'h000002), .REVERSE_ON_FORCE_OR_BOTTOM_MODE_I(mode),
    .CLEAR_LIMITS_I(clr), .SET_UPPER_I(su), .SET_LOWER_I(sl), .OPERATOR_RESET_I(orst),
    .TOOL_CHANGE_I(tc), .ANGLE_O(ang), .UPPER_LIMIT_O(upl), .LOWER_LIMIT_O(lwl),
    .FAULT_O(flt), .STROKE_INHIBIT_O(inh), .CHANNEL3_O(c3), .CHANNEL4_O(c4),
    .RETURN_O(ret), .TONNAGE_O(ton));
  task automatic conclude;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic go(input logic [15:0] p);
    n = 0;
    while (pos !== p && n < 8000) begin @(posedge clk); n++; end
    if (n >= 8000) miscompares++;
    repeat (6) @(posedge clk);
  endtask
  initial begin #240000; miscompares++; conclude; end
  // ----
  // Tests
  // ----
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    go(16'h0100); su <= 1; repeat (6) @(posedge clk); su <= 0; tgt <= 16'h01b4;
    go(16'h01b4); sl <= 1; repeat (6) @(posedge clk); sl <= 0; tgt <= 16'h00f0;
    `CHK(upl, 16'h0100)
    `CHK(lwl, 16'h01b4)
    go(16'h00f0); $display("done limits");
    for (int i = 0; i < 6; i++) begin
      tgt <= rows[i][25:10]; go(rows[i][25:10]);
      `CHK(ang, rows[i][9:1])
      `CHK(ret, rows[i][0])
      `CHK(c4, 1'b0)
    end
    $display("done stroke"); mode <= 1; tgt <= 16'h01c0; n = 0;
    while (c3 !== 1'b1 && n < 8000) begin @(posedge clk); n++; end
    `CHK(c3, 1'b1)
    `CHK(ret, 1'b0)
    `CHK(ton >= 16'h0010, 1'b1)
    n = 0;
    while (c4 !== 1'b1 && n < 8000) begin @(posedge clk); n++; end
    `CHK(n >= 495 && n <= 505, 1'b1)
    `CHK(ret, 1'b1)
    tgt <= 16'h00f0; go(16'h00f0); mode <= 0;
    `CHK(ton, 16'h0000)
    `CHK(flt, 1'b0)
    $display("done force");
    tgt <= 16'h0150; go(16'h0150); tgt <= 16'h00f0; go(16'h00f0);
    `CHK(flt, 1'b1)
    `CHK(inh, 1'b1)
    orst <= 1; repeat (6) @(posedge clk); orst <= 0; repeat (4) @(posedge clk);
    `CHK(flt, 1'b0)
    $display("done fault");
    tgt <= 16'h0130;
    go(16'h0130);
    tc <= 1;
    repeat (6) @(posedge clk);
    tc <= 0;
    `CHK(ret, 1'b1)
    tgt <= 16'h00f0;
    go(16'h00f0);
    `CHK(ret, 1'b0)
    `CHK(flt, 1'b0)
    $display("done tool change");
    tgt <= 16'h01b4;
    go(16'h01b4);
    `CHK(ret, 1'b1)
    rst <= 1;
    repeat (2) @(posedge clk);
    `CHK(ang, 9'h000)
    `CHK(ret, 1'b0)
    `CHK(lwl, 16'h0000)
    rst <= 0;
    repeat (2) @(posedge clk);
    $display("done reset");
    clr <= 1; su <= 1; repeat (6) @(posedge clk);
    `CHK(upl, 16'h0000)
    `CHK(lwl, 16'h0000)
    clr <= 0; su <= 0; $display("done clear");
    conclude;
  end
endmodule // ram_angle_reversal_bench
